/* File: rdpg_pkg.sv */
// Purpose: constants and types for the rail discharge / power-good delay register bank
// Assumes: byte offsets as printed are register indices; APB byte address is four times index
// Notes: delay counts derived from the 100 MHz register clock
package rdpg_pkg;
  localparam int unsigned rdpg_clk_hz = 100_000_000;
  localparam logic [9:0] rdpg_idx_disch_a = 10'h040;
  localparam logic [9:0] rdpg_idx_disch_b = 10'h041;
  localparam logic [9:0] rdpg_idx_disch_c = 10'h042;
  localparam logic [9:0] rdpg_idx_pg_delay = 10'h043;
  localparam logic [9:0] rdpg_idx_shutdown = 10'h091;
  localparam logic [9:0] rdpg_idx_rail_stat = 10'h0f0;
  localparam int unsigned rdpg_num_rails = 11;
  localparam logic [2:0] rdpg_delay_mask = 3'h7;
  localparam logic [7:0] rdpg_disch_c_mask = 8'h3f;
  localparam int unsigned rdpg_force_shutdown_bit_bit = 0;
  localparam logic [1:0] rdpg_disch_none = 2'h0;
  localparam logic [1:0] rdpg_disch_100r = 2'h1;
  localparam logic [1:0] rdpg_disch_200r = 2'h2;
  localparam logic [1:0] rdpg_disch_500r = 2'h3;
  // delay times in microseconds, as printed
  localparam int unsigned rdpg_delay_us [8] = '{2500, 5000, 10000, 15000,
                                                20000, 50000, 75000, 100000};
  localparam int unsigned rdpg_cyc_per_us = rdpg_clk_hz / 1_000_000;
  localparam logic [23:0] rdpg_delay_cyc_max = 24'(100000 * rdpg_cyc_per_us);
  typedef enum logic [1:0] {rdpg_mode_pg, rdpg_mode_level, rdpg_mode_gpo} rdpg_out_mode_e;
  typedef enum logic [1:0] {rdpg_pg_idle, rdpg_pg_count, rdpg_pg_good} rdpg_pg_state_e;
  typedef struct packed {
    logic [7:0] disch_a;
    logic [7:0] disch_b;
    logic [7:0] disch_c;
    logic [2:0] pg_delay;
  } rdpg_otp_s;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rdpg_apb_req_s;
endpackage : rdpg_pkg

/* File: rdpg_regs.sv */
// Purpose: discharge select, output three power-good delay and forced shutdown registers
// Assumes: apb slave, zero wait states; rail enable and in-range flags arrive synchronous
// Notes: discharge fields go to the analog selectors already zeroed for enabled rails
`timescale 1ns/10ps
module rdpg_regs (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire rdpg_pkg::rdpg_otp_s i_otp,
  input wire logic [10:0] i_rail_enabled,
  input wire logic [10:0] i_rail_in_range,
  input wire logic [10:0] i_out3_group,
  input wire rdpg_pkg::rdpg_out_mode_e i_out3_mode,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [21:0] o_discharge_sel,
  output logic o_out3_power_good,
  output logic o_force_shutdown
);
  logic [7:0] disch_a;
  logic [7:0] disch_b;
  logic [7:0] disch_c;
  logic [2:0] pg_delay;
  logic force_shutdown_bit;
  logic otp_load;
  logic [23:0] pg_cnt;
  rdpg_pkg::rdpg_pg_state_e pg_state;
  rdpg_pkg::rdpg_pg_state_e next_pg_state;
  logic [21:0] raw_sel;
  logic [21:0] next_discharge_sel;
  logic [21:0] en_pair;
  wire logic [9:0] idx = i_paddr[11:2];
  wire logic setup = i_psel && !i_penable;
  wire logic access = i_psel && i_penable;
  wire logic wr = access && i_pwrite && i_pstrb[0];
  wire logic hit_a = idx == rdpg_pkg::rdpg_idx_disch_a;
  wire logic hit_b = idx == rdpg_pkg::rdpg_idx_disch_b;
  wire logic hit_c = idx == rdpg_pkg::rdpg_idx_disch_c;
  wire logic hit_d = idx == rdpg_pkg::rdpg_idx_pg_delay;
  wire logic hit_s = idx == rdpg_pkg::rdpg_idx_shutdown;
  wire logic hit_r = idx == rdpg_pkg::rdpg_idx_rail_stat;
  wire logic mapped = hit_a | hit_b | hit_c | hit_d | hit_s | hit_r;
  wire logic force_shutdown_bit_wr = wr && hit_s && i_pwdata[rdpg_pkg::rdpg_force_shutdown_bit_bit];
  wire logic [10:0] watched = i_out3_group & ~i_rail_in_range;
  wire logic group_ok = (i_out3_group != 11'h000) && (watched == 11'h000);
  wire logic pg_mode = i_out3_mode == rdpg_pkg::rdpg_mode_pg;
  wire logic [23:0] delay_cyc = 24'(rdpg_pkg::rdpg_delay_us[pg_delay] *
                                    rdpg_pkg::rdpg_cyc_per_us);
  wire logic [31:0] rd_mux =
    hit_a ? {24'h000000, disch_a} :
    hit_b ? {24'h000000, disch_b} :
    hit_c ? {24'h000000, disch_c & rdpg_pkg::rdpg_disch_c_mask} :
    hit_d ? {29'h00000000, pg_delay} :
    hit_s ? {31'h00000000, force_shutdown_bit} :
    hit_r ? {21'h000000, i_rail_enabled} : 32'h00000000;

  // rail order: a pairs are step-down 1..4, b step-down 5, 6, switch A1, linear 2
  assign raw_sel = {disch_c[5:0], disch_b, disch_a};
  generate
    for (genvar r = 0; r < rdpg_pkg::rdpg_num_rails; r++)
    begin : g_rail
      assign en_pair[2*r+1:2*r] = {2{i_rail_enabled[r]}};
      assign next_discharge_sel[2*r+1:2*r] =
        i_rail_enabled[r] ? rdpg_pkg::rdpg_disch_none : raw_sel[2*r+1:2*r];
    end
  endgenerate

  // shutdown resets the bank synchronously; otp values reloaded the cycle after
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      otp_load <= 1'b1;
    else
      otp_load <= force_shutdown_bit;
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      disch_a <= 8'h00;
      disch_b <= 8'h00;
      disch_c <= 8'h00;
      pg_delay <= 3'h0;
    end
    else if (otp_load || force_shutdown_bit)
    begin
      disch_a <= i_otp.disch_a;
      disch_b <= i_otp.disch_b;
      disch_c <= i_otp.disch_c & rdpg_pkg::rdpg_disch_c_mask;
      pg_delay <= i_otp.pg_delay & rdpg_pkg::rdpg_delay_mask;
    end
    else if (wr)
    begin
      if (hit_a)
        disch_a <= i_pwdata[7:0];
      if (hit_b)
        disch_b <= i_pwdata[7:0];
      if (hit_c)
        disch_c <= i_pwdata[7:0] & rdpg_pkg::rdpg_disch_c_mask;
      if (hit_d)
        pg_delay <= i_pwdata[2:0];
    end
  end

  // self-clearing: held exactly one cycle, its set term is gated by its own inverse so it clears itself
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      force_shutdown_bit <= 1'b0;
    else
      force_shutdown_bit <= force_shutdown_bit_wr && !force_shutdown_bit;
  end

  always_comb
  begin
    next_pg_state = pg_state;
    unique case (pg_state)
      rdpg_pkg::rdpg_pg_idle:
        if (group_ok && pg_mode)
          next_pg_state = rdpg_pkg::rdpg_pg_count;
      rdpg_pkg::rdpg_pg_count:
        if (!group_ok || !pg_mode)
          next_pg_state = rdpg_pkg::rdpg_pg_idle;
        else if (pg_cnt + 24'h000001 >= delay_cyc)
          next_pg_state = rdpg_pkg::rdpg_pg_good;
      rdpg_pkg::rdpg_pg_good:
        if (!group_ok || !pg_mode)
          next_pg_state = rdpg_pkg::rdpg_pg_idle;
      default:
        next_pg_state = rdpg_pkg::rdpg_pg_idle;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pg_state <= rdpg_pkg::rdpg_pg_idle;
      pg_cnt <= 24'h000000;
    end
    else
    begin
      pg_state <= force_shutdown_bit ? rdpg_pkg::rdpg_pg_idle : next_pg_state;
      pg_cnt <= (pg_state == rdpg_pkg::rdpg_pg_count) ? pg_cnt + 24'h000001 : 24'h000000;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_discharge_sel <= 22'h000000;
      o_out3_power_good <= 1'b0;
      o_force_shutdown <= 1'b0;
    end
    else
    begin
      // ready raised in setup so access completes in its first cycle
      o_pready <= setup;
      o_pslverr <= setup && !mapped;
      o_prdata <= (setup && !i_pwrite) ? rd_mux : 32'h00000000;
      o_discharge_sel <= next_discharge_sel;
      o_out3_power_good <= next_pg_state == rdpg_pkg::rdpg_pg_good;
      o_force_shutdown <= force_shutdown_bit_wr && !force_shutdown_bit;
    end
  end

  property p_rail_zero;
    @(posedge i_mclk) disable iff (!i_nrst)
    i_rail_enabled[0] |=> o_discharge_sel[1:0] == 2'h0;
  endproperty
  a_rail_zero: assert property (p_rail_zero) else $error("enabled rail discharges");

  property p_force_shutdown_bit_clear;
    @(posedge i_mclk) disable iff (!i_nrst)
    force_shutdown_bit |=> !force_shutdown_bit;
  endproperty
  a_force_shutdown_bit_clear: assert property (p_force_shutdown_bit_clear) else $error("shutdown bit stuck");

  property p_force_shutdown_bit_pulse;
    @(posedge i_mclk) disable iff (!i_nrst)
    (force_shutdown_bit_wr && !force_shutdown_bit) |=> o_force_shutdown ##1 (otp_load && !o_force_shutdown);
  endproperty
  a_force_shutdown_bit_pulse: assert property (p_force_shutdown_bit_pulse) else $error("shutdown not acted");

  property p_c_top;
    @(posedge i_mclk) disable iff (!i_nrst)
    disch_c[7:6] == 2'h0;
  endproperty
  a_c_top: assert property (p_c_top) else $error("reserved bits set");

  property p_delay_read;
    @(posedge i_mclk) disable iff (!i_nrst)
    (setup && !i_pwrite && hit_d) |=> o_prdata[31:3] == 29'h0 && o_prdata[2:0] == $past(pg_delay);
  endproperty
  a_delay_read: assert property (p_delay_read) else $error("delay readback wrong");

  property p_sd_read;
    @(posedge i_mclk) disable iff (!i_nrst)
    (setup && !i_pwrite && hit_s) |=> o_prdata[31:1] == 31'h0;
  endproperty
  a_sd_read: assert property (p_sd_read) else $error("shutdown reserved bits");

  property p_mode_block;
    @(posedge i_mclk) disable iff (!i_nrst)
    !pg_mode |=> !o_out3_power_good;
  endproperty
  a_mode_block: assert property (p_mode_block) else $error("pg in other mode");

  property p_pg_cause;
    @(posedge i_mclk) disable iff (!i_nrst)
    $rose(o_out3_power_good) |-> $past(pg_state) == rdpg_pkg::rdpg_pg_count
      && $past(pg_cnt) + 24'h1 >= $past(delay_cyc);
  endproperty
  a_pg_cause: assert property (p_pg_cause) else $error("pg early");

  property p_delay0;
    @(posedge i_mclk) disable iff (!i_nrst)
    (pg_state == rdpg_pkg::rdpg_pg_count && pg_delay == 3'h0) |-> delay_cyc == 24'h03d090;
  endproperty
  a_delay0: assert property (p_delay0) else $error("delay code 0 wrong");

  property p_write_a;
    @(posedge i_mclk) disable iff (!i_nrst)
    (wr && hit_a && !force_shutdown_bit && !otp_load) |=> disch_a == $past(i_pwdata[7:0]);
  endproperty
  a_write_a: assert property (p_write_a) else $error("write 40h lost");

  property p_rail_all;
    @(posedge i_mclk) disable iff (!i_nrst)
    1'b1 |=> (o_discharge_sel & $past(en_pair)) == 22'h000000;
  endproperty
  a_rail_all: assert property (p_rail_all) else $error("active rail discharged");

  property p_sel_pass;
    @(posedge i_mclk) disable iff (!i_nrst)
    1'b1 |=> (o_discharge_sel | $past(en_pair)) == ($past(raw_sel) | $past(en_pair));
  endproperty
  a_sel_pass: assert property (p_sel_pass) else $error("code not passed");

  property p_write_b;
    @(posedge i_mclk) disable iff (!i_nrst)
    (wr && hit_b && !force_shutdown_bit && !otp_load) |=> disch_b == $past(i_pwdata[7:0]);
  endproperty
  a_write_b: assert property (p_write_b) else $error("write 41h lost");

  property p_write_c;
    @(posedge i_mclk) disable iff (!i_nrst)
    (wr && hit_c && !force_shutdown_bit && !otp_load) |=>
      disch_c == ($past(i_pwdata[7:0]) & rdpg_pkg::rdpg_disch_c_mask);
  endproperty
  a_write_c: assert property (p_write_c) else $error("write 42h lost");

  property p_write_d;
    @(posedge i_mclk) disable iff (!i_nrst)
    (wr && hit_d && !force_shutdown_bit && !otp_load) |=> pg_delay == $past(i_pwdata[2:0]);
  endproperty
  a_write_d: assert property (p_write_d) else $error("write 43h lost");

  property p_otp_ab;
    @(posedge i_mclk) disable iff (!i_nrst)
    otp_load |=> disch_a == $past(i_otp.disch_a) && disch_b == $past(i_otp.disch_b);
  endproperty
  a_otp_ab: assert property (p_otp_ab) else $error("factory load missed");

  property p_otp_cd;
    @(posedge i_mclk) disable iff (!i_nrst)
    otp_load |=> disch_c == ($past(i_otp.disch_c) & rdpg_pkg::rdpg_disch_c_mask)
      && pg_delay == $past(i_otp.pg_delay);
  endproperty
  a_otp_cd: assert property (p_otp_cd) else $error("factory load missed");

  property p_force_shutdown_bit_zero;
    @(posedge i_mclk) disable iff (!i_nrst)
    (wr && hit_s && !i_pwdata[rdpg_pkg::rdpg_force_shutdown_bit_bit]) |=> !o_force_shutdown;
  endproperty
  a_force_shutdown_bit_zero: assert property (p_force_shutdown_bit_zero) else $error("zero write acted");

  property p_force_shutdown_bit_idle;
    @(posedge i_mclk) disable iff (!i_nrst)
    force_shutdown_bit |=> pg_state == rdpg_pkg::rdpg_pg_idle;
  endproperty
  a_force_shutdown_bit_idle: assert property (p_force_shutdown_bit_idle) else $error("pg survives");

  property p_force_shutdown_bit_reload;
    @(posedge i_mclk) disable iff (!i_nrst)
    force_shutdown_bit |=> disch_a == $past(i_otp.disch_a) && disch_b == $past(i_otp.disch_b);
  endproperty
  a_force_shutdown_bit_reload: assert property (p_force_shutdown_bit_reload) else $error("bank not reset");

  property p_sd_zero_read;
    @(posedge i_mclk) disable iff (!i_nrst)
    (setup && !i_pwrite && hit_s && !force_shutdown_bit) |=> o_prdata == 32'h00000000;
  endproperty
  a_sd_zero_read: assert property (p_sd_zero_read) else $error("bit not cleared");

  property p_pg_rails;
    @(posedge i_mclk) disable iff (!i_nrst)
    !group_ok |=> !o_out3_power_good;
  endproperty
  a_pg_rails: assert property (p_pg_rails) else $error("pg before all rails");

  property p_pg_cnt_idle;
    @(posedge i_mclk) disable iff (!i_nrst)
    (pg_state != rdpg_pkg::rdpg_pg_count) |=> pg_cnt == 24'h000000;
  endproperty
  a_pg_cnt_idle: assert property (p_pg_cnt_idle) else $error("delay count stale");

  property p_pg_hold;
    @(posedge i_mclk) disable iff (!i_nrst)
    (pg_state == rdpg_pkg::rdpg_pg_good && group_ok && pg_mode) |=> o_out3_power_good;
  endproperty
  a_pg_hold: assert property (p_pg_hold) else $error("pg dropped");

  property p_delay7;
    @(posedge i_mclk) disable iff (!i_nrst)
    (pg_delay == 3'h7) |-> delay_cyc == 24'h989680;
  endproperty
  a_delay7: assert property (p_delay7) else $error("delay code 7 wrong");

  property p_c_read;
    @(posedge i_mclk) disable iff (!i_nrst)
    (setup && !i_pwrite && hit_c) |=> o_prdata[31:6] == 26'h0;
  endproperty
  a_c_read: assert property (p_c_read) else $error("42h top bits read");
endmodule : rdpg_regs

/* File: rdpg_host.sv */
// Purpose: host side of the register bus, an apb master that software uses
// Assumes: one transfer at a time, full byte strobes
// Notes: waits on pready without a limit; the bench watchdog cuts a hang
`timescale 1ns/10ps
module rdpg_host (
  input wire logic i_mclk,
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [11:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic [3:0] o_pstrb
);
  initial
  begin
    {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
    o_pstrb = 4'hf;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge i_mclk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_mclk);
    o_penable <= 1'b1;
    do @(posedge i_mclk); while (i_pready !== 1'b1);
    rd = i_prdata;
    err = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask : xfer
endmodule : rdpg_host

/* File: tb.sv */
// Purpose: self-checking bench of the discharge, delay and shutdown registers
// Assumes: otp values random but fixed for the run
// Notes: full power-good delays exceed the run, so only early and masked cases
`timescale 1ns/10ps
module tb;
  logic clk, nrst, psel, pen, pwr, pready, pslverr, pg, force_shutdown_bit, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [3:0] pstrb;
  logic [21:0] dsel;
  logic [10:0] en, rng, grp;
  rdpg_pkg::rdpg_otp_s otp;
  rdpg_pkg::rdpg_out_mode_e mode;
  logic [7:0] m [4];
  logic [9:0] ix [4] = '{rdpg_pkg::rdpg_idx_disch_a, rdpg_pkg::rdpg_idx_disch_b,
                         rdpg_pkg::rdpg_idx_disch_c, rdpg_pkg::rdpg_idx_pg_delay};
  logic [7:0] mk [4] = '{8'hff, 8'hff, rdpg_pkg::rdpg_disch_c_mask, 8'h07};
  logic [31:0] seed = 32'hfbe14264;
  int error_cnt = 0;
  int n_checks = 0;
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  rdpg_host host (.i_mclk(clk), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr),
    .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata),
    .o_pstrb(pstrb));
  rdpg_regs dut (.i_mclk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .i_otp(otp), .i_rail_enabled(en),
    .i_rail_in_range(rng), .i_out3_group(grp), .i_out3_mode(mode), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_discharge_sel(dsel),
    .o_out3_power_good(pg), .o_force_shutdown(force_shutdown_bit));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // fields of enabled rails are expected forced to no discharge
  function automatic logic [21:0] dexp(input logic [10:0] e);
    logic [21:0] x;
    x = {m[2][5:0], m[1], m[0]};
    for (int r = 0; r < 11; r++)
      if (e[r])
        x[2*r+:2] = rdpg_pkg::rdpg_disch_none;
    return x;
  endfunction : dexp
  // delay code to 100 MHz cycles: tenths of a millisecond times ten thousand
  function automatic logic [31:0] dly(input logic [2:0] c);
    logic [31:0] t;
    case (c)
      3'h0: t = 32'h19;
      3'h1: t = 32'h32;
      3'h2: t = 32'h64;
      3'h3: t = 32'h96;
      3'h4: t = 32'hc8;
      3'h5: t = 32'h1f4;
      3'h6: t = 32'h2ee;
      default: t = 32'h3e8;
    endcase
    return t * 32'h2710;
  endfunction : dly
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rd_chk(input logic [9:0] i, input logic [31:0] e, input logic e_err);
    host.xfer(1'b0, {i, 2'b00}, 32'h0, rd, err);
    chk(rd, e);
    chk({31'h0, err}, {31'h0, e_err});
  endtask : rd_chk
  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    host.xfer(1'b1, {i, 2'b00}, d, rd, err);
  endtask : wr
  task automatic load_otp();
    m[0] = otp.disch_a;
    m[1] = otp.disch_b;
    m[2] = otp.disch_c & mk[2];
    m[3] = {5'h0, otp.pg_delay};
  endtask : load_otp
  task automatic chk_regs();
    for (int k = 0; k < 4; k++)
      rd_chk(ix[k], {24'h0, m[k]}, 1'b0);
  endtask : chk_regs
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
  initial
  begin
    {nrst, en, rng, grp} = '0;
    mode = rdpg_pkg::rdpg_mode_pg;
    otp = 27'(rnd());
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    load_otp();
    chk_regs();
    rd_chk(rdpg_pkg::rdpg_idx_shutdown, 32'h0, 1'b0);
    $display("reset values done");
    for (int n = 0; n < 24; n++)
    begin
      v = (n < 4) ? 32'hffffffff : rnd();
      wr(ix[n%4], v);
      m[n%4] = v[7:0] & mk[n%4];
    end
    chk_regs();
    for (int n = 0; n < 10; n++)
    begin
      @(posedge clk);
      en <= (n == 0) ? 11'h0 : 11'(rnd());
      @(posedge clk);
      #1 chk(32'(dsel), 32'(dexp(en)));
    end
    rd_chk(10'h3ff, 32'h0, 1'b1);
    $display("discharge fields done");
    wr(rdpg_pkg::rdpg_idx_shutdown, 32'hfe);
    #1 chk({31'h0, force_shutdown_bit}, 32'h0);
    rd_chk(rdpg_pkg::rdpg_idx_shutdown, 32'h0, 1'b0);
    wr(rdpg_pkg::rdpg_idx_shutdown, 32'h1);
    #1 chk({31'h0, force_shutdown_bit}, 32'h1);
    @(posedge clk);
    #1 chk({31'h0, force_shutdown_bit}, 32'h0);
    rd_chk(rdpg_pkg::rdpg_idx_shutdown, 32'h0, 1'b0);
    load_otp();
    chk_regs();
    $display("shutdown done");
    for (int k = 0; k < 8; k++)
    begin
      wr(rdpg_pkg::rdpg_idx_pg_delay, 32'(k));
      #1 chk(32'(dut.delay_cyc), dly(3'(k)));
    end
    wr(rdpg_pkg::rdpg_idx_pg_delay, 32'h0);
    @(posedge clk);
    grp <= 11'h0f3;
    rng <= 11'h0f1;
    repeat (300) @(posedge clk);
    // one grouped rail still out of range, so nothing counts
    #1 chk(32'(dut.pg_cnt), 32'h0);
    @(posedge clk);
    rng <= 11'h0f3;
    mode <= rdpg_pkg::rdpg_mode_level;
    repeat (300) @(posedge clk);
    #1 chk({31'h0, pg}, 32'h0);
    chk(32'(dut.pg_cnt), 32'h0);
    @(posedge clk);
    mode <= rdpg_pkg::rdpg_mode_gpo;
    repeat (300) @(posedge clk);
    #1 chk(32'(dut.pg_cnt), 32'h0);
    @(posedge clk);
    mode <= rdpg_pkg::rdpg_mode_pg;
    // far below the shortest delay; counting starts the cycle after the mode is seen
    repeat (2000) @(posedge clk);
    #1 chk({31'h0, pg}, 32'h0);
    chk(32'(dut.pg_cnt), 32'h7cf);
    @(posedge clk);
    rng <= 11'h0f1;
    repeat (2) @(posedge clk);
    #1 chk(32'(dut.pg_cnt), 32'h0);
    $display("power good done");
    stop_test();
  end
endmodule : tb
